/* rtl/process_alarm_relay_select.v */
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"

module process_alarm_relay_select (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // Avalon-MM slave
   input wire [`ADDR_W+1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output wire [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   output wire [1:0] o_avs_response,
   // Process inputs
   input wire signed [`PCT_W-1:0] i_process_value,
   input wire signed [`PCT_W-1:0] i_setpoint,
   input wire signed [`PCT_W-1:0] i_run_variable,
   input wire signed [`PCT_W-1:0] i_speed_reference,
   // Drive status flags, one per status source
   input wire [`NUM_STAT-1:0] i_drive_status,
   // Relay and interrupt
   output wire o_relay,
   output wire o_irq,
   // Display
   output reg [`PCT_W-1:0] o_disp_top,
   output reg [`PCT_W-1:0] o_disp_bottom,
   output reg o_disp_units_process
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   reg signed [`PCT_W-1:0] high_thresh;
   reg signed [`PCT_W-1:0] low_thresh;
   reg [`SRC_W-1:0] option_relay_source;
   reg [`SRC_W-1:0] browse_source;
   reg loop_output_view;
   reg [15:0] run_display_scale;
   reg [15:0] process_display_scale;
   reg [`IRQ_W-1:0] irq_status;
   reg [`IRQ_W-1:0] irq_mask;
   reg [31:0] readdata;
   reg rd_done;
   wire process_high_alarm;
   wire process_low_alarm;
   wire relay_drive;
   reg high_d;
   reg low_d;
   reg relay_d;

   // Single-word writes only take the low 16 bits when both low lanes enabled
   wire wr_ok = i_avs_write && (i_avs_byteenable[1:0] == 2'b11);
   wire [`ADDR_W-1:0] widx = i_avs_address[`ADDR_W+1:2];
   wire wr_ctrl = wr_ok && (widx == `REG_CTRL);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function signed [`PCT_W-1:0] clamp_pct;
      input signed [`PCT_W-1:0] v;
      begin
         if (v > `PCT_MAX) begin
            clamp_pct = `PCT_MAX;
         end else if (v < `PCT_MIN) begin
            clamp_pct = `PCT_MIN;
         end else begin
            clamp_pct = v;
         end
      end
   endfunction

   function [`SRC_W-1:0] step_src;
      input [`SRC_W-1:0] s;
      input up;
      begin
         if (up) begin
            step_src = (s == `SRC_LAST) ? `SRC_RUN : s + 5'h01;
         end else begin
            step_src = (s == `SRC_RUN) ? `SRC_LAST : s - 5'h01;
         end
      end
   endfunction

   function [31:0] sx;
      input [`PCT_W-1:0] v;
      begin
         sx = {{(32-`PCT_W){v[`PCT_W-1]}}, v};
      end
   endfunction

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         high_thresh <= `HIGH_THR_RST;
         low_thresh <= `LOW_THR_RST;
         option_relay_source <= `SRC_RUN;
         browse_source <= `SRC_RUN;
         loop_output_view <= 1'b0;
         run_display_scale <= `SCALE_RST;
         process_display_scale <= `SCALE_RST;
         irq_mask <= {`IRQ_W{1'b0}};
      end else begin
         if (wr_ok) begin
            case (widx)
               `REG_HIGH: high_thresh <= clamp_pct(i_avs_writedata[`PCT_W-1:0]);
               `REG_LOW: low_thresh <= clamp_pct(i_avs_writedata[`PCT_W-1:0]);
               `REG_MASK: irq_mask <= i_avs_writedata[`IRQ_W-1:0];
               `REG_DISP: begin
                  run_display_scale <= i_avs_writedata[15:0];
               end
               `REG_SEL: process_display_scale <= i_avs_writedata[15:0];
               default: irq_mask <= irq_mask;
            endcase
         end
         if (wr_ctrl) begin
            loop_output_view <= i_avs_writedata[`CTRL_LOOPVIEW];
            if (i_avs_writedata[`CTRL_ABORT]) begin
               browse_source <= option_relay_source;
            end else if (i_avs_writedata[`CTRL_ACCEPT]) begin
               option_relay_source <= browse_source;
            end else if (i_avs_writedata[`CTRL_UP]) begin
               browse_source <= step_src(browse_source, 1'b1);
            end else if (i_avs_writedata[`CTRL_DOWN]) begin
               browse_source <= step_src(browse_source, 1'b0);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Alarms and relay
   // ------------------------------------------------------------
   // No gating by loop state
   hyst_compare u_high (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_above(1'b1),
      .i_value(i_process_value),
      .i_thresh(high_thresh),
      .o_alarm(process_high_alarm)
   );

   hyst_compare u_low (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_above(1'b0),
      .i_value(i_process_value),
      .i_thresh(low_thresh),
      .o_alarm(process_low_alarm)
   );

   relay_source_mux u_mux (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_source(option_relay_source),
      .i_status(i_drive_status),
      .i_high_alarm(process_high_alarm),
      .i_low_alarm(process_low_alarm),
      .o_relay(relay_drive)
   );

   assign o_relay = relay_drive;

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   wire [`IRQ_W-1:0] irq_set;
   assign irq_set[`IRQ_HIGH] = process_high_alarm & ~high_d;
   assign irq_set[`IRQ_LOW] = process_low_alarm & ~low_d;
   assign irq_set[`IRQ_RELAY] = relay_drive ^ relay_d;
   wire [`IRQ_W-1:0] irq_clr = (wr_ok && widx == `REG_IRQ) ?
                               i_avs_writedata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_status <= {`IRQ_W{1'b0}};
         high_d <= 1'b0;
         low_d <= 1'b0;
         relay_d <= 1'b0;
      end else begin
         high_d <= process_high_alarm;
         low_d <= process_low_alarm;
         relay_d <= relay_drive;
         // Set beats clear so no edge is lost
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // Display
   // ------------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_disp_top <= {`PCT_W{1'b0}};
         o_disp_bottom <= {`PCT_W{1'b0}};
         o_disp_units_process <= 1'b0;
      end else if (loop_output_view) begin
         o_disp_top <= i_process_value;
         o_disp_bottom <= i_setpoint;
         o_disp_units_process <= 1'b1;
      end else begin
         o_disp_top <= i_run_variable;
         o_disp_bottom <= i_speed_reference;
         o_disp_units_process <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Bus read path
   // ------------------------------------------------------------
   // Reads take one wait cycle so data come from a register
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         readdata <= 32'h0000_0000;
         rd_done <= 1'b0;
      end else begin
         rd_done <= i_avs_read && !rd_done;
         // Capture once per read so data stand until the next access
         if (i_avs_read && !rd_done) begin
            case (widx)
               `REG_CTRL: readdata <= {27'h000_0000, loop_output_view, 4'h0};
               `REG_HIGH: readdata <= sx(high_thresh);
               `REG_LOW: readdata <= sx(low_thresh);
               `REG_SRC: readdata <= {16'h0000, 3'h0, browse_source, 3'h0, option_relay_source};
               `REG_STAT: readdata <= {29'h0000_0000, relay_drive, process_low_alarm,
                                       process_high_alarm};
               `REG_IRQ: readdata <= {29'h0000_0000, irq_status};
               `REG_MASK: readdata <= {29'h0000_0000, irq_mask};
               `REG_DISP: readdata <= {16'h0000, run_display_scale};
               `REG_SEL: readdata <= {16'h0000, process_display_scale};
               default: readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign o_avs_waitrequest = i_avs_read && !rd_done;
   assign o_avs_readdata = readdata;
   // Unmapped indices answer decode error
   assign o_avs_response = (widx > `REG_SEL) ? 2'b11 : 2'b00;

endmodule

/* rtl/alarm_relay_defines.vh */
`ifndef ALARM_RELAY_DEFINES_VH
`define ALARM_RELAY_DEFINES_VH

// Percent values are signed 16-bit tenths of a percent
`define PCT_W 16
`define PCT_MAX 16'sd1000
`define PCT_MIN -16'sd1000
`define HIGH_THR_RST 16'h0320
`define LOW_THR_RST 16'h00C8
// Half of the 2% band: set/clear one percent either side
`define HYST_HALF 16'h000A
// Display scale registers reset to 100
`define SCALE_RST 16'h0064

// Relay source codes
`define SRC_W 5
`define SRC_RUN 5'h00
`define SRC_TRIP 5'h01
`define SRC_OVERRIDE 5'h02
`define SRC_PROOF 5'h03
`define SRC_ZERO 5'h04
`define SRC_ATSPD 5'h05
`define SRC_UNDER 5'h06
`define SRC_OVER 5'h07
`define SRC_ON 5'h08
`define SRC_OFF 5'h09
`define SRC_ARFAIL 5'h0A
`define SRC_FWD 5'h0B
`define SRC_REV 5'h0C
`define SRC_ENA 5'h0D
`define SRC_OVLD 5'h0E
`define SRC_TEMP 5'h0F
`define SRC_PHIGH 5'h10
`define SRC_PLOW 5'h11
`define SRC_LAST 5'h11
`define NUM_STAT 14

// Register word offsets (byte address is the offset times four)
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_HIGH 4'h1
`define REG_LOW 4'h2
`define REG_SRC 4'h3
`define REG_STAT 4'h4
`define REG_IRQ 4'h5
`define REG_MASK 4'h6
`define REG_DISP 4'h7
`define REG_SEL 4'h8

// Control bits
`define CTRL_UP 0
`define CTRL_DOWN 1
`define CTRL_ACCEPT 2
`define CTRL_ABORT 3
`define CTRL_LOOPVIEW 4

// Interrupt bits
`define IRQ_W 3
`define IRQ_HIGH 0
`define IRQ_LOW 1
`define IRQ_RELAY 2

`endif

/* rtl/hyst_compare.v */
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"

module hyst_compare (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // Compare
   input wire i_above,
   input wire signed [`PCT_W-1:0] i_value,
   input wire signed [`PCT_W-1:0] i_thresh,
   output reg o_alarm
);

   wire signed [`PCT_W:0] set_lvl;
   wire signed [`PCT_W:0] clr_lvl;
   wire signed [`PCT_W:0] val;

   assign val = {i_value[`PCT_W-1], i_value};
   // Band edges one percent either side of threshold
   assign set_lvl = i_above ? ({i_thresh[`PCT_W-1], i_thresh} + $signed({1'b0, `HYST_HALF}))
                            : ({i_thresh[`PCT_W-1], i_thresh} - $signed({1'b0, `HYST_HALF}));
   assign clr_lvl = i_above ? ({i_thresh[`PCT_W-1], i_thresh} - $signed({1'b0, `HYST_HALF}))
                            : ({i_thresh[`PCT_W-1], i_thresh} + $signed({1'b0, `HYST_HALF}));

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_alarm <= 1'b0;
      end else if (i_above) begin
         if (val > set_lvl) begin
            o_alarm <= 1'b1;
         end else if (val < clr_lvl) begin
            o_alarm <= 1'b0;
         end
      end else begin
         if (val < set_lvl) begin
            o_alarm <= 1'b1;
         end else if (val > clr_lvl) begin
            o_alarm <= 1'b0;
         end
      end
   end

endmodule

/* rtl/relay_source_mux.v */
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"

module relay_source_mux (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // Selection
   input wire [`SRC_W-1:0] i_source,
   input wire [`NUM_STAT-1:0] i_status,
   input wire i_high_alarm,
   input wire i_low_alarm,
   // Relay
   output reg o_relay
);

   reg next_relay;
   reg [`NUM_STAT-1:0] pick;
   integer k;

   // One-hot decode of the drive status codes, skipping the forced pair
   always @* begin
      pick = {`NUM_STAT{1'b0}};
      for (k = 0; k < `NUM_STAT; k = k + 1) begin
         if (k < 8) begin
            pick[k] = (i_source == k[`SRC_W-1:0]);
         end else begin
            pick[k] = (i_source == (k[`SRC_W-1:0] + 5'h02));
         end
      end
   end

   always @* begin
      next_relay = |(pick & i_status);
      case (i_source)
         `SRC_ON: next_relay = 1'b1;
         `SRC_OFF: next_relay = 1'b0;
         `SRC_PHIGH: next_relay = i_high_alarm;
         `SRC_PLOW: next_relay = i_low_alarm;
         default: next_relay = next_relay;
      endcase
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_relay <= 1'b0;
      end else begin
         o_relay <= next_relay;
      end
   end

endmodule

/* testbench/alarm_relay_monitor.sv */
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"

module alarm_relay_monitor (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst_b,
   // Bus
   input wire [`ADDR_W+1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire [1:0] o_avs_response,
   // Process side
   input wire signed [`PCT_W-1:0] i_process_value,
   input wire signed [`PCT_W-1:0] i_setpoint,
   input wire signed [`PCT_W-1:0] i_run_variable,
   input wire signed [`PCT_W-1:0] i_speed_reference,
   input wire [`NUM_STAT-1:0] i_drive_status,
   input wire o_relay,
   input wire o_irq,
   input wire [`PCT_W-1:0] o_disp_top,
   input wire [`PCT_W-1:0] o_disp_bottom,
   input wire o_disp_units_process
);
   logic view;
   logic [1:0] quiet;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // ------
   // Shadow state
   // ------
   // Any write counts as a cause, so the quiet check stays conservative
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         view <= 1'b0;
         quiet <= 2'd0;
      end else begin
         if (i_avs_write && i_avs_byteenable[1:0] == 2'b11 && i_avs_address[5:2] == `REG_CTRL)
            view <= i_avs_writedata[`CTRL_LOOPVIEW];
         if (i_avs_write || !$stable(i_process_value) || !$stable(i_drive_status))
            quiet <= 2'd0;
         else if (quiet != 2'd3)
            quiet <= quiet + 2'd1;
      end
   end
   // ------
   // Properties
   // ------
   a_write_nowait: assert property (i_avs_write |-> !o_avs_waitrequest)
      else $error("write stalled");
   a_read_wait: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("read wait state wrong");
   a_resp_map: assert property ((i_avs_read || i_avs_write) |->
      o_avs_response == ((i_avs_address[5:2] > 4'h8) ? 2'b11 : 2'b00)) else $error("bad response");
   a_read_hold: assert property (!i_avs_read && !i_avs_write |=> $stable(o_avs_readdata))
      else $error("read data moved");
   a_loop_view: assert property ($past(i_rst_b) && $past(view) && $past(view, 2) |->
      o_disp_top == $past(i_process_value) && o_disp_bottom == $past(i_setpoint)
      && o_disp_units_process) else $error("loop view wrong");
   a_std_view: assert property ($past(i_rst_b) && !$past(view) && !$past(view, 2) |->
      o_disp_top == $past(i_run_variable) && o_disp_bottom == $past(i_speed_reference)
      && !o_disp_units_process) else $error("standard view wrong");
   a_relay_steady: assert property (quiet == 2'd3 |-> $stable(o_relay))
      else $error("relay moved without cause");
   a_irq_steady: assert property (quiet == 2'd3 |-> $stable(o_irq))
      else $error("irq moved without cause");
   c_loop: cover property (view && o_disp_units_process);
   c_relay: cover property ($rose(o_relay));
   c_unmapped: cover property (o_avs_response == 2'b11);
endmodule

bind process_alarm_relay_select alarm_relay_monitor u_alarm_relay_monitor (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
   .i_process_value(i_process_value), .i_setpoint(i_setpoint),
   .i_run_variable(i_run_variable), .i_speed_reference(i_speed_reference),
   .i_drive_status(i_drive_status), .o_relay(o_relay), .o_irq(o_irq),
   .o_disp_top(o_disp_top), .o_disp_bottom(o_disp_bottom),
   .o_disp_units_process(o_disp_units_process));

/* testbench/drive_side_model.sv */
`timescale 1ns/10ps

module drive_side_model (
   // Clock
   input wire i_clk_sys,
   // Process signals
   output logic signed [15:0] o_process_value,
   output logic signed [15:0] o_setpoint,
   output logic signed [15:0] o_run_variable,
   output logic signed [15:0] o_speed_reference,
   // Status flags
   output logic [13:0] o_drive_status
);
   // Fixed references keep display checks simple
   initial begin
      o_process_value = 16'h01f4;
      o_setpoint = 16'h0123;
      o_run_variable = 16'h0456;
      o_speed_reference = 16'h0789;
      o_drive_status = 14'h0000;
   end
   // New values land just after an edge, like a sampled transducer
   task apply(input logic [15:0] v, input logic [13:0] s);
      @(posedge i_clk_sys);
      o_process_value <= v;
      o_drive_status <= s;
   endtask
endmodule

/* testbench/process_alarm_relay_select_bench.sv */
`timescale 1ns/10ps
`include "alarm_relay_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module process_alarm_relay_select_bench;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata, readdata;
   logic [1:0] rresp, resp;
   logic waitreq, relay, irq, units;
   logic [15:0] top, bottom;
   logic signed [15:0] pv, sp, rv, sref;
   logic [13:0] status, hot;
   int error_cnt = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [15:0] pv_tab[9] = '{16'h01f4, 16'h032a, 16'h032b, 16'h0316, 16'h0315,
      16'h00be, 16'h00bd, 16'h00d2, 16'h00d3};
   logic [1:0] al_tab[9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0};

   process_alarm_relay_select u_process_alarm_relay_select (
      .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .o_avs_response(resp),
      .i_process_value(pv), .i_setpoint(sp), .i_run_variable(rv), .i_speed_reference(sref),
      .i_drive_status(status), .o_relay(relay), .o_irq(irq), .o_disp_top(top),
      .o_disp_bottom(bottom), .o_disp_units_process(units));
   drive_side_model u_drive_side_model (.i_clk_sys(clk_sys), .o_process_value(pv),
      .o_setpoint(sp), .o_run_variable(rv), .o_speed_reference(sref), .o_drive_status(status));

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task print_verdict();
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Request held until the rising edge that sees waitrequest low; only the timeout ends a hang
   task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= {idx, 2'b00};
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge clk_sys);
      while (waitreq !== 1'b0) begin
         @(posedge clk_sys);
      end
      rdata = readdata;
      rresp = resp;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task check_reg(input logic [3:0] idx, input logic [31:0] e);
      bus(1'b0, idx, 32'h0000_0000);
      `CHK(rdata, e)
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      check_reg(`REG_HIGH, 32'h0000_0320);
      check_reg(`REG_LOW, 32'h0000_00c8);
      check_reg(`REG_SRC, 32'h0000_0000);
      check_reg(`REG_SEL, 32'h0000_0064);
      check_reg(`REG_DISP, 32'h0000_0064);
      bus(1'b1, `REG_HIGH, 32'h0000_7fff);
      check_reg(`REG_HIGH, 32'h0000_03e8);
      bus(1'b1, `REG_LOW, 32'hffff_f830);
      check_reg(`REG_LOW, 32'hffff_fc18);
      be <= 4'hc;
      bus(1'b1, `REG_HIGH, 32'h0000_0320);
      be <= 4'hf;
      check_reg(`REG_HIGH, 32'h0000_03e8);
      bus(1'b1, `REG_HIGH, 32'h0000_0320);
      bus(1'b1, `REG_LOW, 32'h0000_00c8);
      bus(1'b0, 4'h9, 32'h0000_0000);
      `CHK({rresp, rdata}, 34'h3_0000_0000)
      for (int i = 0; i < 9; i++) begin
         u_drive_side_model.apply(pv_tab[i], 14'h0000);
         tick(3);
         check_reg(`REG_STAT, 32'(al_tab[i]));
      end
      bus(1'b1, `REG_IRQ, 32'h0000_0007);
      check_reg(`REG_IRQ, 32'h0000_0000);
      bus(1'b1, `REG_MASK, 32'h0000_0001);
      u_drive_side_model.apply(16'h0384, 14'h0000);
      tick(4);
      `CHK(irq, 1'b1)
      check_reg(`REG_IRQ, 32'h0000_0001);
      bus(1'b1, `REG_IRQ, 32'h0000_0001);
      tick(1);
      `CHK(irq, 1'b0)
      bus(1'b1, `REG_MASK, 32'h0000_0000);
      u_drive_side_model.apply(16'h01f4, 14'h0000);
      tick(4);
      u_drive_side_model.apply(16'h0384, 14'h0000);
      tick(4);
      `CHK(irq, 1'b0)
      check_reg(`REG_IRQ, 32'h0000_0001);
      bus(1'b1, `REG_IRQ, 32'h0000_0007);
      for (int k = 0; k < 18; k++) begin
         if (k > 0) begin
            bus(1'b1, `REG_CTRL, 32'h0000_0001);
            bus(1'b1, `REG_CTRL, 32'h0000_0004);
         end
         check_reg(`REG_SRC, (k << 8) | k);
         for (int p = 0; p < 2; p++) begin
            hot = 14'h0001 << ((k < 8) ? k : k - 2);
            u_drive_side_model.apply(p ? 16'h0064 : 16'h0384, p ? ~hot : hot);
            tick(4);
            `CHK(relay, (k == 8) || (k != 9 && (p == 0) == (k != 17)))
         end
      end
      check_reg(`REG_IRQ, 32'h0000_0007);
      bus(1'b1, `REG_CTRL, 32'h0000_0001);
      bus(1'b1, `REG_CTRL, 32'h0000_0004);
      check_reg(`REG_SRC, 32'h0000_0000);
      bus(1'b1, `REG_CTRL, 32'h0000_0002);
      bus(1'b1, `REG_CTRL, 32'h0000_0004);
      check_reg(`REG_SRC, 32'h0000_1111);
      bus(1'b1, `REG_CTRL, 32'h0000_0001);
      bus(1'b1, `REG_CTRL, 32'h0000_0008);
      check_reg(`REG_SRC, 32'h0000_1111);
      u_drive_side_model.apply(16'h0384, 14'h3fff);
      tick(4);
      `CHK(relay, 1'b0)
      `CHK({units, top, bottom}, 33'h0_0456_0789)
      bus(1'b1, `REG_CTRL, 32'h0000_0010);
      check_reg(`REG_CTRL, 32'h0000_0010);
      tick(2);
      `CHK({units, top, bottom}, 33'h1_0384_0123)
      bus(1'b1, `REG_CTRL, 32'h0000_0000);
      tick(2);
      `CHK({units, top, bottom}, 33'h0_0456_0789)
      print_verdict();
   end
endmodule
